// ===== logic/srpc_dev.sv
`timescale 1ns/10ps
module srpc_dev (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   srpc_link_if.dev link,
   input wire logic mult_select_pin_i,
   input wire logic mult_select_driven_i,
   input wire logic out_drive_enable_i,
   input wire logic pll_clk_i,
   output logic clock_out_o,
   output logic clock_out_complement_o,
   output logic [7:0] ref_divider_control_o,
   output logic [7:0] feedback_divider_o,
   output logic [7:0] reserved_byte_o,
   output logic [9:0] fb_div_eff_o,
   output logic [6:0] ref_div_eff_o
);
   typedef enum {D_IDLE, D_ADDR, D_ACK, D_WR, D_RD, D_RACK, D_IGN} srpc_dstate_t;

   srpc_dstate_t st_q;
   logic scl_s1_q, scl_s2_q, scl_p_q;
   logic sda_s1_q, sda_s2_q, sda_p_q;
   logic oe_s1_q, oe_s2_q;
   logic ms_s1_q, ms_s2_q, msd_s1_q, msd_s2_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [2:0] byte_q;
   logic [1:0] rd_idx_q;
   logic rw_q;
   logic mack_q;
   logic drv_q;
   logic [7:0] ref_ctl_q, fb_q, rsv_q;
   logic [9:0] fb_eff_q, fb_eff_d;
   logic [6:0] ref_eff_q, ref_eff_d;

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
         oe_s1_q <= 1'b0;
         oe_s2_q <= 1'b0;
         ms_s1_q <= 1'b1;
         ms_s2_q <= 1'b1;
         msd_s1_q <= 1'b0;
         msd_s2_q <= 1'b0;
      end else begin
         scl_s1_q <= link.scl;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= link.sda;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
         oe_s1_q <= out_drive_enable_i;
         oe_s2_q <= oe_s1_q;
         ms_s1_q <= mult_select_pin_i;
         ms_s2_q <= ms_s1_q;
         msd_s1_q <= mult_select_driven_i;
         msd_s2_q <= msd_s1_q;
      end
   end

   // ==========================================================
   // bus condition decode
   wire start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   wire stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   wire scl_rise = scl_s2_q & ~scl_p_q;
   wire scl_fall = ~scl_s2_q & scl_p_q;
   wire byte_done = (bit_q == srpc_pkg::BITS_PER_BYTE);
   wire addr_hit = (sh_q[7:1] == srpc_pkg::DEV_ADDR);
   wire [2:0] byte_inc = (byte_q == srpc_pkg::BYTE_IDX_MAX) ? byte_q : byte_q + 3'h1;
   wire [7:0] rd_byte = (rd_idx_q == 2'h0) ? ref_ctl_q :
                        (rd_idx_q == 2'h1) ? fb_q :
                        (rd_idx_q == 2'h2) ? rsv_q : srpc_pkg::RD_PAST_END;
   wire [1:0] rd_inc = (rd_idx_q == srpc_pkg::RD_IDX_MAX) ? rd_idx_q : rd_idx_q + 2'h1;

   // ==========================================================
   // serial slave engine
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_q <= D_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         byte_q <= 3'h0;
         rd_idx_q <= 2'h0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         drv_q <= 1'b0;
         ref_ctl_q <= srpc_pkg::REF_CTL_RST;
         fb_q <= srpc_pkg::FB_DIV_RST;
         rsv_q <= srpc_pkg::RSV_RST;
      end else if (start_det) begin
         st_q <= D_ADDR;
         bit_q <= 4'h0;
         byte_q <= 3'h0;
         rd_idx_q <= 2'h0;
         drv_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= D_IDLE;
         drv_q <= 1'b0;
      end else begin
         case (st_q)
            D_ADDR, D_WR: begin
               if (scl_rise && !byte_done) begin
                  sh_q <= {sh_q[6:0], sda_s2_q};
                  bit_q <= bit_q + 4'h1;
               end
               if (scl_fall && byte_done) begin
                  if (st_q == D_ADDR) begin
                     if (addr_hit) begin
                        drv_q <= 1'b1;
                        rw_q <= sh_q[0];
                        st_q <= D_ACK;
                     end else begin
                        st_q <= D_IGN;
                     end
                  end else begin
                     if (byte_q == srpc_pkg::LATCH0_IDX) begin
                        ref_ctl_q <= sh_q;
                     end
                     if (byte_q == srpc_pkg::LATCH1_IDX) begin
                        fb_q <= sh_q;
                     end
                     if (byte_q == srpc_pkg::LATCH2_IDX) begin
                        rsv_q <= sh_q;
                     end
                     byte_q <= byte_inc;
                     drv_q <= 1'b1;
                     st_q <= D_ACK;
                  end
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     sh_q <= rd_byte;
                     drv_q <= ~rd_byte[7];
                     bit_q <= 4'h1;
                     rd_idx_q <= rd_inc;
                     st_q <= D_RD;
                  end else begin
                     drv_q <= 1'b0;
                     bit_q <= 4'h0;
                     st_q <= D_WR;
                  end
               end
            end
            D_RD: begin
               if (scl_fall) begin
                  if (byte_done) begin
                     drv_q <= 1'b0;
                     st_q <= D_RACK;
                  end else begin
                     drv_q <= ~sh_q[6];
                     sh_q <= {sh_q[6:0], 1'b0};
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end
            D_RACK: begin
               if (scl_rise) begin
                  mack_q <= ~sda_s2_q;
               end
               if (scl_fall) begin
                  if (mack_q) begin
                     sh_q <= rd_byte;
                     drv_q <= ~rd_byte[7];
                     bit_q <= 4'h1;
                     rd_idx_q <= rd_inc;
                     st_q <= D_RD;
                  end else begin
                     st_q <= D_IGN;
                  end
               end
            end
            D_IDLE, D_IGN: begin
               drv_q <= 1'b0;
            end
            default: begin
               st_q <= D_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // divider selection
   wire mult_pin = msd_s2_q ? ms_s2_q : 1'b1;
   wire [9:0] fb_serial = 10'((10'(fb_q) + srpc_pkg::FB_ADD) << 1);
   wire [6:0] ref_serial = ref_ctl_q[srpc_pkg::REF_BYP_BIT] ? srpc_pkg::REF_UNITY :
                           7'(ref_ctl_q[srpc_pkg::REF_VAL_MSB:0]) + srpc_pkg::REF_ADD;
   wire [9:0] fb_pin = mult_pin ? srpc_pkg::MULT_PIN_HIGH : srpc_pkg::MULT_PIN_LOW;

   always_comb begin
      if (ref_ctl_q[srpc_pkg::RATIO_SEL_BIT]) begin
         fb_eff_d = fb_serial;
         ref_eff_d = ref_serial;
      end else begin
         fb_eff_d = fb_pin;
         ref_eff_d = srpc_pkg::REF_UNITY;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         fb_eff_q <= srpc_pkg::MULT_PIN_HIGH;
         ref_eff_q <= srpc_pkg::REF_UNITY;
      end else begin
         fb_eff_q <= fb_eff_d;
         ref_eff_q <= ref_eff_d;
      end
   end

   // ==========================================================
   // outputs
   assign link.d_sda_o = 1'b0;
   assign link.d_sda_oe = drv_q;
   assign clock_out_o = pll_clk_i & oe_s2_q;
   assign clock_out_complement_o = ~pll_clk_i & oe_s2_q;
   assign ref_divider_control_o = ref_ctl_q;
   assign feedback_divider_o = fb_q;
   assign reserved_byte_o = rsv_q;
   assign fb_div_eff_o = fb_eff_q;
   assign ref_div_eff_o = ref_eff_q;
endmodule

// ===== logic/srpc_pkg.sv
package srpc_pkg;
   // ==========================================================
   // serial port address and frame layout
   localparam logic [6:0] DEV_ADDR = 7'h65;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] LATCH0_IDX = 3'h2;
   localparam logic [2:0] LATCH1_IDX = 3'h3;
   localparam logic [2:0] LATCH2_IDX = 3'h4;
   localparam logic [2:0] BYTE_IDX_MAX = 3'h7;
   localparam logic [1:0] RD_IDX_MAX = 2'h3;
   localparam logic [7:0] RD_PAST_END = 8'hFF;
   // ==========================================================
   // byte latch fields and reset values
   localparam int REF_BYP_BIT = 7;
   localparam int RATIO_SEL_BIT = 6;
   localparam int REF_VAL_MSB = 5;
   localparam logic [7:0] REF_CTL_RST = 8'h00;
   localparam logic [7:0] FB_DIV_RST = 8'h00;
   localparam logic [7:0] RSV_RST = 8'h00;
   // ==========================================================
   // divider arithmetic
   localparam logic [9:0] MULT_PIN_LOW = 10'h010;
   localparam logic [9:0] MULT_PIN_HIGH = 10'h008;
   localparam logic [9:0] FB_ADD = 10'h003;
   localparam logic [6:0] REF_ADD = 7'h02;
   localparam logic [6:0] REF_UNITY = 7'h01;
   // ==========================================================
   // controller timing
   localparam int CLK_NS = 4;
   localparam int SCL_PERIOD_NS = 480;
   localparam logic [9:0] SCL_QTR_CYC = 10'(SCL_PERIOD_NS / (4 * CLK_NS));
   // ==========================================================
   // controller register map
   localparam logic [3:0] CMD_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam int CMD_BYTE_LSB = 0;
   localparam int CMD_START_BIT = 8;
   localparam int CMD_STOP_BIT = 9;
   localparam int CMD_READ_BIT = 10;
   localparam int CMD_NACK_BIT = 11;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RX_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ===== logic/srpc_link_if.sv
`timescale 1ns/10ps
interface srpc_link_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda;
   // ==========================================================
   // open-drain data line with pull-up
   assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport mst (output scl, input sda, output m_sda_o, output m_sda_oe);
endinterface

// ===== logic/srpc_mst.sv
`timescale 1ns/10ps
module srpc_mst (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   srpc_link_if.mst link,
   input wire logic axi_awvalid_i,
   output logic axi_awready_o,
   input wire logic [3:0] axi_awaddr_i,
   input wire logic axi_wvalid_i,
   output logic axi_wready_o,
   input wire logic [31:0] axi_wdata_i,
   input wire logic [3:0] axi_wstrb_i,
   output logic axi_bvalid_o,
   input wire logic axi_bready_i,
   output logic [1:0] axi_bresp_o,
   input wire logic axi_arvalid_i,
   output logic axi_arready_o,
   input wire logic [3:0] axi_araddr_i,
   output logic axi_rvalid_o,
   input wire logic axi_rready_i,
   output logic [31:0] axi_rdata_o,
   output logic [1:0] axi_rresp_o
);
   typedef enum {M_IDLE, M_START, M_BIT, M_STOP} srpc_mstate_t;

   srpc_mstate_t st_q;
   logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0] bresp_q, rresp_q;
   logic [11:0] cmd_q;
   logic busy_q, nack_q, scl_q, sda_q;
   logic [7:0] tx_q, rx_q;
   logic [9:0] tick_q;
   logic [1:0] qph_q;
   logic [3:0] bit_q;
   logic sda_s1_q, sda_s2_q;

   // ==========================================================
   // register bus decode
   wire aw_hs = axi_awvalid_i & axi_awready_o;
   wire w_hs = axi_wvalid_i & axi_wready_o;
   wire do_wr = (aw_got_q | aw_hs) & (w_got_q | w_hs);
   wire [3:0] wr_addr = aw_got_q ? awaddr_q : axi_awaddr_i;
   wire [31:0] wr_data = w_got_q ? wdata_q : axi_wdata_i;
   wire wr_cmd = do_wr & (wr_addr == srpc_pkg::CMD_OFS);
   wire wr_ok = wr_cmd | (wr_addr == srpc_pkg::STAT_OFS);
   wire go = wr_cmd & ~busy_q & axi_wstrb_i[0] & axi_wstrb_i[1];
   wire ar_hs = axi_arvalid_i & axi_arready_o;
   wire rd_ok = (axi_araddr_i == srpc_pkg::CMD_OFS) | (axi_araddr_i == srpc_pkg::STAT_OFS);
   wire [31:0] stat_word = (32'(rx_q) << srpc_pkg::STAT_RX_LSB) |
                           (32'(nack_q) << srpc_pkg::STAT_NACK_BIT) |
                           (32'(busy_q) << srpc_pkg::STAT_BUSY_BIT);
   wire [31:0] rd_word = (axi_araddr_i == srpc_pkg::CMD_OFS) ? 32'(cmd_q) : stat_word;
   wire qtick = (tick_q == srpc_pkg::SCL_QTR_CYC - 10'h001);
   wire is_read = cmd_q[srpc_pkg::CMD_READ_BIT];
   wire last_bit = (bit_q == srpc_pkg::BITS_PER_BYTE);
   wire ack_level = is_read ? cmd_q[srpc_pkg::CMD_NACK_BIT] : 1'b1;

   assign axi_awready_o = ~aw_got_q & ~bvalid_q;
   assign axi_wready_o = ~w_got_q & ~bvalid_q;
   assign axi_arready_o = ~rvalid_q;
   assign axi_bvalid_o = bvalid_q;
   assign axi_bresp_o = bresp_q;
   assign axi_rvalid_o = rvalid_q;
   assign axi_rdata_o = rdata_q;
   assign axi_rresp_o = rresp_q;

   // ==========================================================
   // register bus slave
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         bvalid_q <= 1'b0;
         bresp_q <= srpc_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= srpc_pkg::RESP_OKAY;
      end else begin
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? srpc_pkg::RESP_OKAY : srpc_pkg::RESP_DECERR;
         end else begin
            if (aw_hs) begin
               aw_got_q <= 1'b1;
               awaddr_q <= axi_awaddr_i;
            end
            if (w_hs) begin
               w_got_q <= 1'b1;
               wdata_q <= axi_wdata_i;
            end
            if (bvalid_q && axi_bready_i) begin
               bvalid_q <= 1'b0;
            end
         end
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_word : 32'h0000_0000;
            rresp_q <= rd_ok ? srpc_pkg::RESP_OKAY : srpc_pkg::RESP_DECERR;
         end else if (rvalid_q && axi_rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // serial master engine
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         sda_s1_q <= link.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_q <= M_IDLE;
         cmd_q <= 12'h000;
         busy_q <= 1'b0;
         nack_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         tick_q <= 10'h000;
         qph_q <= 2'h0;
         bit_q <= 4'h0;
      end else if (st_q == M_IDLE) begin
         tick_q <= 10'h000;
         qph_q <= 2'h0;
         bit_q <= 4'h0;
         if (go) begin
            cmd_q <= wr_data[11:0];
            busy_q <= 1'b1;
            tx_q <= wr_data[srpc_pkg::CMD_READ_BIT] ? 8'hFF : wr_data[7:0];
            st_q <= wr_data[srpc_pkg::CMD_START_BIT] ? M_START : M_BIT;
         end
      end else begin
         tick_q <= qtick ? 10'h000 : tick_q + 10'h001;
         if (qtick) begin
            qph_q <= qph_q + 2'h1;
            case (st_q)
               M_START: begin
                  case (qph_q)
                     2'h0: sda_q <= 1'b1;
                     2'h1: scl_q <= 1'b1;
                     2'h2: sda_q <= 1'b0;
                     default: begin
                        scl_q <= 1'b0;
                        st_q <= M_BIT;
                     end
                  endcase
               end
               M_BIT: begin
                  case (qph_q)
                     2'h0: sda_q <= last_bit ? ack_level : tx_q[7];
                     2'h1: scl_q <= 1'b1;
                     2'h2: begin
                        if (!last_bit) begin
                           rx_q <= {rx_q[6:0], sda_s2_q};
                        end else if (!is_read) begin
                           nack_q <= sda_s2_q;
                        end
                     end
                     default: begin
                        scl_q <= 1'b0;
                        tx_q <= {tx_q[6:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (last_bit) begin
                           if (cmd_q[srpc_pkg::CMD_STOP_BIT]) begin
                              st_q <= M_STOP;
                           end else begin
                              busy_q <= 1'b0;
                              st_q <= M_IDLE;
                           end
                        end
                     end
                  endcase
               end
               M_STOP: begin
                  case (qph_q)
                     2'h0: sda_q <= 1'b0;
                     2'h1: scl_q <= 1'b1;
                     2'h2: sda_q <= 1'b1;
                     default: begin
                        busy_q <= 1'b0;
                        st_q <= M_IDLE;
                     end
                  endcase
               end
               default: st_q <= M_IDLE;
            endcase
         end
      end
   end

   assign link.scl = scl_q;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = ~sda_q;
endmodule

// ===== tb/srpc_link_checker.sv
`timescale 1ns/10ps
module srpc_link_checker (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic sda
);
   // ==========================================================
   // frame tracking
   logic scl_q, sda_q, rd_q, ign_q;
   logic [3:0] cnt_q;
   logic [2:0] byte_q;
   logic [7:0] sh_q;
   wire start_w = scl & scl_q & sda_q & ~sda;
   wire rise_w = scl & ~scl_q;
   wire fall_w = ~scl & scl_q;
   wire ack_w = rise_w & (cnt_q == 4'h8);
   wire match_w = (sh_q[7:1] == srpc_pkg::DEV_ADDR);
   wire rd_bit_w = fall_w & (cnt_q != 4'h0) & (byte_q != 3'h0) & rd_q & ~ign_q;
   always_ff @(posedge clk_sys_i) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || start_w) begin
         cnt_q <= 4'h0;
         byte_q <= 3'h0;
      end else if (ack_w) begin
         cnt_q <= 4'h0;
         byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
      end else if (rise_w) begin
         cnt_q <= cnt_q + 4'h1;
         sh_q <= {sh_q[6:0], sda};
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || start_w) begin
         ign_q <= 1'b0;
         rd_q <= 1'b0;
      end else if (ack_w && byte_q == 3'h0) begin
         ign_q <= ~match_w;
         rd_q <= sh_q[0];
      end
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   dev_stable_high_a: assert property (scl && scl_q |-> $stable(d_sda_oe))
      else $error("device data moved while clock high");
   ack_setup_a: assert property (ack_w && byte_q == 3'h0 && match_w |-> $past(d_sda_oe))
      else $error("address ack not pulled before rising edge");
   addr_ack_a: assert property (ack_w && byte_q == 3'h0 && match_w |-> !sda [*8])
      else $error("own address not acknowledged");
   foreign_nack_a: assert property (ack_w && byte_q == 3'h0 && !match_w |-> sda)
      else $error("foreign address acknowledged");
   ignore_idle_a: assert property (ign_q |-> !d_sda_oe)
      else $error("device drove after foreign address");
   write_ack_a: assert property (ack_w && byte_q != 3'h0 && !rd_q && !ign_q |-> !sda && d_sda_oe)
      else $error("written byte not acknowledged");
   read_release_a: assert property (rd_bit_w |-> !m_sda_oe)
      else $error("master drove during read data");
   master_ack_read_a: assert property (ack_w && byte_q != 3'h0 && rd_q |-> !d_sda_oe)
      else $error("device drove during master ack");
   master_only_cond_a: assert property (scl && scl_q && $changed(m_sda_oe) |-> !d_sda_oe)
      else $error("start or stop while device drives");
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clk_sys, rst_n, pll_clk, sel_pin, sel_drv, oe_pin, ah, wh;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, st, rd;
   logic [1:0] bresp, rresp, rs, br;
   logic clk_out, clk_out_n;
   logic [7:0] lat0, lat1, lat2;
   logic [9:0] fb_eff;
   logic [6:0] ref_eff;
   int err_total, checks_done;
   logic [1:0] pins [3] = '{2'h2, 2'h3, 2'h0};
   logic [9:0] mults [3] = '{10'h010, 10'h008, 10'h008};
   logic [11:0] f1 [7] = '{12'h1CA, 12'h011, 12'h022, 12'h045, 12'h040, 12'h099, 12'h277};
   logic [11:0] f2 [4] = '{12'h1CA, 12'h000, 12'h000, 12'h2C5};
   logic [11:0] rc [3] = '{12'h400, 12'h400, 12'hE00};
   logic [7:0] rx [3] = '{8'hC5, 8'h40, 8'h99};
   srpc_link_if srpc_link_if_inst();
   srpc_mst srpc_mst_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .link(srpc_link_if_inst),
      .axi_awvalid_i(awvalid), .axi_awready_o(awready), .axi_awaddr_i(awaddr),
      .axi_wvalid_i(wvalid), .axi_wready_o(wready), .axi_wdata_i(wdata), .axi_wstrb_i(wstrb),
      .axi_bvalid_o(bvalid), .axi_bready_i(bready), .axi_bresp_o(bresp),
      .axi_arvalid_i(arvalid), .axi_arready_o(arready), .axi_araddr_i(araddr),
      .axi_rvalid_o(rvalid), .axi_rready_i(rready), .axi_rdata_o(rdata), .axi_rresp_o(rresp));
   srpc_dev srpc_dev_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .link(srpc_link_if_inst),
      .mult_select_pin_i(sel_pin), .mult_select_driven_i(sel_drv),
      .out_drive_enable_i(oe_pin), .pll_clk_i(pll_clk), .clock_out_o(clk_out),
      .clock_out_complement_o(clk_out_n), .ref_divider_control_o(lat0),
      .feedback_divider_o(lat1), .reserved_byte_o(lat2), .fb_div_eff_o(fb_eff),
      .ref_div_eff_o(ref_eff));
   srpc_link_checker srpc_link_checker_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
      .scl(srpc_link_if_inst.scl), .m_sda_o(srpc_link_if_inst.m_sda_o),
      .m_sda_oe(srpc_link_if_inst.m_sda_oe), .d_sda_o(srpc_link_if_inst.d_sda_o),
      .d_sda_oe(srpc_link_if_inst.d_sda_oe), .sda(srpc_link_if_inst.sda));
   // ==========================================================
   // clocks and helpers
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) pll_clk <= ~pll_clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h want %h", $time, g, e);
         err_total++;
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk_sys);
         ah = !ad && awready;
         wh = !wd && wready;
         @(posedge clk_sys);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         ad = ad | ah;
         wd = wd | wh;
      end
      do @(negedge clk_sys); while (bvalid !== 1'b1);
      br = bresp;
      @(posedge clk_sys);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk_sys);
         ah = arready;
         @(posedge clk_sys);
      end while (ah !== 1'b1);
      arvalid <= 1'b0;
      do @(negedge clk_sys); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      rready <= 1'b0;
   endtask
   task automatic op(input logic [11:0] c);
      axi_wr(srpc_pkg::CMD_OFS, {20'h0, c});
      chk(32'(br), 32'(srpc_pkg::RESP_OKAY));
      do axi_rd(srpc_pkg::STAT_OFS, st, rs); while (st[srpc_pkg::STAT_BUSY_BIT] !== 1'b0);
      chk(32'(rs), 32'(srpc_pkg::RESP_OKAY));
   endtask
   // ==========================================================
   // tests
   initial begin
      #240000;
      err_total++;
      end_sim();
   end
   initial begin
      err_total = 0;
      checks_done = 0;
      {rst_n, pll_clk, sel_pin, sel_drv, oe_pin, awvalid, wvalid, bready, arvalid, rready} = 0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(32'({lat0, lat1, lat2}), 32'h0);
      chk(32'(fb_eff), 32'h8);
      chk(32'({clk_out, clk_out_n}), 32'h0);
      for (int i = 0; i < 3; i++) begin
         sel_drv <= pins[i][1];
         sel_pin <= pins[i][0];
         repeat (5) @(posedge clk_sys);
         chk(32'({fb_eff, ref_eff}), 32'({mults[i], 7'h01}));
      end
      oe_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
      repeat (2) begin
         @(negedge clk_sys);
         chk(32'({clk_out, clk_out_n}), 32'({pll_clk, ~pll_clk}));
      end
      @(posedge clk_sys);
      oe_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(32'({clk_out, clk_out_n}), 32'h0);
      axi_rd(4'h8, rd, rs);
      chk(32'(rs), 32'(srpc_pkg::RESP_DECERR));
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         op(f1[i]);
         chk(32'(st[srpc_pkg::STAT_NACK_BIT]), 32'h0);
      end
      chk(32'({lat0, lat1, lat2}), 32'h454099);
      chk(32'({fb_eff, ref_eff}), 32'({10'h086, 7'h07}));
      for (int i = 0; i < 4; i++) op(f2[i]);
      chk(32'({lat0, lat1}), 32'hC540);
      chk(32'({fb_eff, ref_eff}), 32'({10'h086, 7'h01}));
      op(12'h1CB);
      chk(32'(st[srpc_pkg::STAT_NACK_BIT]), 32'h0);
      for (int i = 0; i < 3; i++) begin
         op(rc[i]);
         chk(32'(st[15:8]), 32'(rx[i]));
      end
      op(12'h3CC);
      chk(32'(st[srpc_pkg::STAT_NACK_BIT]), 32'h1);
      chk(32'({lat0, lat1, lat2}), 32'hC54099);
      wstrb <= 4'h1;
      axi_wr(srpc_pkg::CMD_OFS, 32'h0000_01CA);
      wstrb <= 4'hF;
      axi_rd(srpc_pkg::CMD_OFS, rd, rs);
      chk(rd, 32'h0000_03CC);
      end_sim();
   end
endmodule
